/* File: hdl/mpsd_pkg.sv */
// Package: field layout, opcodes, register map and carrier types of the microprogram sequencer
package mpsd_pkg;

  // Word and field layout
  localparam int          WORD_W        = 32;
  localparam int          ADDR_W        = 6;
  localparam int          DATA_LSB      = 16;
  localparam int          DATA_W        = 6;
  localparam int          TEST_LSB      = 22;
  localparam int          TEST_W        = 3;
  localparam int          POL_BIT       = 25;
  localparam int          OP_LSB        = 26;
  localparam int          OP_W          = 5;
  localparam int          OE_BIT        = 31;
  localparam int          CMP_CONST_LSB = 22;
  localparam int          CMP_CONST_W   = 6;
  localparam int          CMP_OP_LSB    = 28;
  localparam int          CMP_OP_W      = 3;
  localparam logic [2:0]  CMP_OP_VAL    = 3'h7;
  localparam logic [5:0]  RESET_ADDR    = 6'h3F;

  // General opcodes; codes 1C..1F are taken by the compare format
  localparam logic [4:0] OP_CONT          = 5'h00;
  localparam logic [4:0] OP_LOOP_JUMP     = 5'h18;
  localparam logic [4:0] OP_LOOP_RLD_DATA = 5'h19;
  localparam logic [4:0] OP_LOOP_RLD_TEST = 5'h1A;
  localparam logic [4:0] OP_LOOP_OR_COND  = 5'h1B;
  localparam logic [2:0] LOOP_GROUP       = 3'h6;

  // Test select codes beyond the six test inputs
  localparam logic [2:0] TSEL_COND  = 3'h6;
  localparam logic [2:0] TSEL_EQUAL = 3'h7;

  // Wishbone register map (byte addresses)
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_PIPE   = 12'h008;
  localparam logic [11:0] REG_SHADOW = 12'h00C;
  localparam logic [3:0]  MEM_PAGE   = 4'h1;
  localparam int          CTRL_DIAG_BIT  = 0;
  localparam logic        CTRL_DIAG_RST  = 1'b0;
  localparam int          STAT_PC_LSB    = 0;
  localparam int          STAT_CTR_LSB   = 8;
  localparam int          STAT_STK_LSB   = 16;
  localparam int          STAT_EQ_BIT    = 24;
  localparam int          STAT_ZERO_BIT  = 25;
  localparam int          STAT_BOOT_BIT  = 26;

  // Source selector for next address, return stack and loop counter
  typedef enum logic [6:0] {
    SRC_NONE = 7'h01,
    SRC_DATA = 7'h02,
    SRC_MASK = 7'h04,
    SRC_STK  = 7'h08,
    SRC_CTR  = 7'h10,
    SRC_PC1  = 7'h20,
    SRC_DECR = 7'h40
  } mpsd_src_t;

  // Action of one conditional opcode
  typedef struct packed {
    mpsd_src_t dst;
    mpsd_src_t stk;
    mpsd_src_t ctr;
  } mpsd_act_t;

  // Sequencer state
  typedef enum logic [1:0] {
    ST_BOOT = 2'h1,
    ST_RUN  = 2'h2
  } mpsd_state_t;

endpackage : mpsd_pkg

/* File: hdl/mpsd_sequencer.sv */
// Microprogram sequencer with loop counter, return stack, compare flag and shadow-register diagnostics
// Contract
// - Twenty-nine opcodes in looping, conditional and unconditional groups.
// - Looping with counter nonzero decrements it and jumps to the data field; the or-condition variant decrements and steps on only if its condition fails.
// - Looping with counter zero falls through to the next address, except the or-condition variant.
// - A looping variant reloads the counter from data or tests at zero.
// - A looping variant jumps to data when counter is zero or condition holds.
// - A false conditional does nothing and goes to the next address.
// - Plain conditional jumps and calls take the data field as target.
// - Masked jumps and calls target the test inputs ANDed with the mask.
// - Action runs when test is true with polarity clear, false with it set.
// - Conditional opcodes push the address, load or decrement the counter.
// - Continue drives the outputs and moves to the next address.
// - Compare sets the equal flag from masked tests against a constant.
// - Diagnostic mode repurposes one input and three outputs.
// - Condition input becomes serial in; outputs become shift clock, mode, serial out.
// - Mode low shifts serial data in one bit per shift clock.
// - Mode high with serial in low captures the pipeline into the shadow.
// - Normally the pipeline loads the next word from memory each clock.
// - In diagnostics, mode high loads the pipeline from the shadow register.
// - General format: data 16-21, test 22-24, polarity 25, opcode 26-30.
// - Compare format: mask 16-21, constant 22-27, opcode 28-30.
// - Six-bit loop counter with zero detect drives loops and zero output.
// - Active-low reset forces the microprogram address to 63.
//
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
module mpsd_sequencer
  import mpsd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Test inputs
  input  wire logic [5:0]  test_in,
  input  wire logic        condition_input,
  // Control outputs
  output logic      [15:0] ctrl_out,
  output logic             ctrl_hi_oe,
  output logic             zero_n,
  // Repurposed diagnostic pins
  input  wire logic        diag_shift_clock_i,
  output logic             diag_shift_clock_o,
  output logic             diag_shift_clock_oe,
  input  wire logic        diag_mode_i,
  output logic             diag_mode_o,
  output logic             diag_mode_oe,
  output logic             shadow_serial_out
);

  // Program memory, written over the bus, read asynchronously by the fetch
  logic [WORD_W-1:0] mem [0:63];

  logic [WORD_W-1:0] pipe_r, pipe_nxt, shadow_r, shadow_nxt;
  logic [5:0]        pc_r, pc_nxt, loop_counter_r, loop_counter_nxt;
  logic [5:0]        return_stack_reg_r, return_stack_reg_nxt;
  logic              equal_flag_r, equal_flag_nxt;
  logic              diag_en_r, diag_shift_clock_prev_r, ack_r, zero_n_r, sdo_r;
  logic              diag_shift_clock_o_r, mode_o_r, diag_oe_r;
  logic [31:0]       rdat_r;
  logic [63:0]       word_set_r;   // Words written since power-up; not reset, like the memory
  mpsd_state_t       st_r, st_nxt;

  // Select one of the sources; NONE keeps the given current value
  function automatic logic [5:0] pick(input mpsd_src_t s, input logic [5:0] cur,
                                      input logic [5:0] d, input logic [5:0] m,
                                      input logic [5:0] stk, input logic [5:0] ctr,
                                      input logic [5:0] inc);
    unique case (s)
      SRC_DATA: pick = d;
      SRC_MASK: pick = m;
      SRC_STK:  pick = stk;
      SRC_CTR:  pick = ctr;
      SRC_PC1:  pick = inc;
      SRC_DECR: pick = ctr - 6'h01;
      default:  pick = cur;
    endcase
  endfunction : pick

  // Conditional opcode table: next address, stack and counter sources
  function automatic mpsd_act_t op_action(input logic [4:0] op);
    unique case (op)
      5'h01:   op_action = '{SRC_DATA, SRC_NONE, SRC_NONE}; // Jump to data
      5'h02:   op_action = '{SRC_MASK, SRC_NONE, SRC_NONE}; // masked_multiway_jump
      5'h03:   op_action = '{SRC_STK,  SRC_NONE, SRC_NONE}; // Return
      5'h04:   op_action = '{SRC_CTR,  SRC_NONE, SRC_NONE}; // Jump to counter value
      5'h05:   op_action = '{SRC_DATA, SRC_PC1,  SRC_NONE}; // Call data
      5'h06:   op_action = '{SRC_MASK, SRC_PC1,  SRC_NONE}; // Masked call
      5'h07:   op_action = '{SRC_CTR,  SRC_PC1,  SRC_NONE}; // Call counter value
      5'h08:   op_action = '{SRC_NONE, SRC_PC1,  SRC_NONE}; // Push address
      5'h09:   op_action = '{SRC_NONE, SRC_DATA, SRC_NONE}; // Push data
      5'h0A:   op_action = '{SRC_NONE, SRC_MASK, SRC_NONE}; // Push masked tests
      5'h0B:   op_action = '{SRC_NONE, SRC_CTR,  SRC_NONE}; // Push counter, nested counters
      5'h0C:   op_action = '{SRC_NONE, SRC_NONE, SRC_DATA}; // Load counter
      5'h0D:   op_action = '{SRC_NONE, SRC_NONE, SRC_MASK}; // Load masked tests
      5'h0E:   op_action = '{SRC_NONE, SRC_NONE, SRC_STK};  // Load from stack
      5'h0F:   op_action = '{SRC_NONE, SRC_NONE, SRC_DECR}; // Decrement
      5'h10:   op_action = '{SRC_DATA, SRC_NONE, SRC_DECR}; // Decrement and jump
      5'h11:   op_action = '{SRC_MASK, SRC_NONE, SRC_DECR}; // Decrement and masked jump
      5'h12:   op_action = '{SRC_STK,  SRC_NONE, SRC_DECR}; // Decrement and return
      5'h13:   op_action = '{SRC_STK,  SRC_NONE, SRC_DATA}; // Return and load
      5'h14:   op_action = '{SRC_STK,  SRC_NONE, SRC_MASK}; // Return and load masked
      5'h15:   op_action = '{SRC_DATA, SRC_PC1,  SRC_MASK}; // Call and load masked
      5'h16:   op_action = '{SRC_DATA, SRC_CTR,  SRC_NONE}; // Jump, save counter
      5'h17:   op_action = '{SRC_NONE, SRC_CTR,  SRC_STK};  // Swap stack and counter
      default: op_action = '{SRC_NONE, SRC_NONE, SRC_NONE};
    endcase
  endfunction : op_action

  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    merge = old;
  endfunction : merge

  // Field decode of the word being executed
  wire logic [4:0]  op        = pipe_r[OP_LSB +: OP_W];
  wire logic [5:0]  data      = pipe_r[DATA_LSB +: DATA_W];
  wire logic [2:0]  tsel      = pipe_r[TEST_LSB +: TEST_W];
  wire logic        pol       = pipe_r[POL_BIT];
  wire logic [5:0]  cmp_const = pipe_r[CMP_CONST_LSB +: CMP_CONST_W];
  wire logic        is_cmp    = pipe_r[CMP_OP_LSB +: CMP_OP_W] == CMP_OP_VAL;
  wire logic        is_loop   = !is_cmp && (op[4:2] == LOOP_GROUP);
  wire logic        is_cont   = !is_cmp && (op == OP_CONT);
  wire logic        running   = st_r == ST_RUN;
  wire mpsd_act_t   act       = op_action(op);

  // Condition: the pin is serial data in while diagnostics own it
  wire logic        cond_pin  = diag_en_r ? 1'b0 : condition_input;
  wire logic [7:0]  tvec      = {equal_flag_r, cond_pin, test_in};
  wire logic        cond      = tvec[tsel] ^ pol;
  wire logic [5:0]  masked    = test_in & data;
  wire logic [5:0]  pc_inc    = pc_r + 6'h01;
  wire logic        ctr_zero  = loop_counter_r == 6'h00;
  wire logic        cmp_hit   = masked == cmp_const;
  wire logic        cond_op   = running && !is_cmp && !is_loop && !is_cont;

  // Next address, counter, stack and flag; any unlisted case is a plain step
  always_comb begin
    pc_nxt               = pc_inc;
    loop_counter_nxt     = loop_counter_r;
    return_stack_reg_nxt = return_stack_reg_r;
    equal_flag_nxt       = equal_flag_r;
    if (!running) begin
      pc_nxt = pc_r;
    end else if (is_cmp) begin
      equal_flag_nxt = cmp_hit;
    end else if (is_loop) begin
      unique case (op)
        OP_LOOP_OR_COND: begin
          if (ctr_zero || cond) begin
            pc_nxt = data;
          end else begin
            loop_counter_nxt = loop_counter_r - 6'h01;
          end
        end
        default: begin
          if (!ctr_zero) begin
            loop_counter_nxt = loop_counter_r - 6'h01;
            pc_nxt           = data;
          end else if (op == OP_LOOP_RLD_DATA) begin
            loop_counter_nxt = data;
          end else if (op == OP_LOOP_RLD_TEST) begin
            loop_counter_nxt = test_in;
          end
        end                                                             // Zero falls through
      endcase
    end else if (!is_cont && cond) begin
      pc_nxt               = pick(act.dst, pc_inc, data, masked, return_stack_reg_r,
                                  loop_counter_r, pc_inc);
      return_stack_reg_nxt = pick(act.stk, return_stack_reg_r, data, masked,
                                  return_stack_reg_r, loop_counter_r, pc_inc);
      loop_counter_nxt     = pick(act.ctr, loop_counter_r, data, masked,
                                  return_stack_reg_r, loop_counter_r, pc_inc);
    end
    // A false test or continue leaves everything and steps on
  end

  // Diagnostic shift clock edge; inputs are already synchronous to clk
  wire logic        diag_shift_clock_rise = diag_en_r && diag_shift_clock_i && !diag_shift_clock_prev_r;
  wire logic        pipe_load = diag_en_r && diag_mode_i;

  // Shadow register: shift in at bit 0, send bit 31 out first
  always_comb begin
    shadow_nxt = shadow_r;
    if (diag_shift_clock_rise && !diag_mode_i) begin
      shadow_nxt = {shadow_r[30:0], condition_input};
    end else if (diag_shift_clock_rise && !condition_input) begin
      shadow_nxt = pipe_r;
    end
  end

  // Pipeline source: shadow in diagnostics with mode high, else memory
  assign pipe_nxt = pipe_load ? shadow_r : mem[pc_nxt];
  assign st_nxt   = ST_RUN;

  // Sequencer registers; reset forces address 63 and one fetch cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r               <= ST_BOOT;
      pc_r               <= RESET_ADDR;
      pipe_r             <= '0;
      loop_counter_r     <= '0;
      return_stack_reg_r <= '0;
      equal_flag_r       <= 1'b0;
    end else begin
      st_r               <= st_nxt;
      pc_r               <= pc_nxt;
      pipe_r             <= pipe_nxt;
      loop_counter_r     <= loop_counter_nxt;
      return_stack_reg_r <= return_stack_reg_nxt;
      equal_flag_r       <= equal_flag_nxt;
    end
  end

  // Diagnostic pins: outputs in normal mode, tester-driven in diagnostics
  always_ff @(posedge clk) begin
    if (!rstn) begin
      shadow_r    <= '0;
      diag_shift_clock_prev_r <= 1'b0;
      diag_oe_r   <= 1'b1;
      diag_shift_clock_o_r    <= 1'b0;
      mode_o_r    <= 1'b0;
      sdo_r       <= 1'b0;
      zero_n_r    <= 1'b0;
    end else begin
      shadow_r    <= shadow_nxt;
      diag_shift_clock_prev_r <= diag_shift_clock_i;
      diag_oe_r   <= !diag_en_r;
      diag_shift_clock_o_r    <= pipe_nxt[0];
      mode_o_r    <= pipe_nxt[1];
      sdo_r       <= diag_en_r ? shadow_nxt[31] : pipe_nxt[2];
      zero_n_r    <= loop_counter_nxt != 6'h00;
    end
  end

  // Wishbone decode; ack one cycle after the request, dropped the next
  wire logic        wb_hit   = wb_cyc_i && wb_stb_i;
  wire logic        mem_sel  = wb_adr_i[11:8] == MEM_PAGE;
  wire logic [5:0]  mem_idx  = wb_adr_i[7:2];
  wire logic        wr_fire  = wb_hit && ack_r && wb_we_i;
  wire logic [11:0] reg_adr  = {wb_adr_i[11:2], 2'b00};
  wire logic [31:0] status_w = (32'(pc_r) << STAT_PC_LSB) | (32'(loop_counter_r) << STAT_CTR_LSB)
                             | (32'(return_stack_reg_r) << STAT_STK_LSB)
                             | (32'(equal_flag_r) << STAT_EQ_BIT) | (32'(ctr_zero) << STAT_ZERO_BIT)
                             | (32'(!running) << STAT_BOOT_BIT);
  wire logic [31:0] rd_mux   = mem_sel                 ? mem[mem_idx] :
                               (reg_adr == REG_CTRL)   ? (32'(diag_en_r) << CTRL_DIAG_BIT) :
                               (reg_adr == REG_STATUS) ? status_w :
                               (reg_adr == REG_PIPE)   ? pipe_r :
                               (reg_adr == REG_SHADOW) ? shadow_r : 32'h0000_0000;

  // Bus handshake and control register; unmapped reads give zero, writes vanish
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ack_r     <= 1'b0;
      rdat_r    <= '0;
      diag_en_r <= CTRL_DIAG_RST;
    end else begin
      ack_r <= wb_hit && !ack_r;
      if (wb_hit && !ack_r) begin
        rdat_r <= rd_mux;
      end
      if (wr_fire && !mem_sel && reg_adr == REG_CTRL && wb_sel_i[0]) begin
        diag_en_r <= wb_dat_i[CTRL_DIAG_BIT];
      end
    end
  end

  // Program memory write; words are not reset, software loads them before use
  always_ff @(posedge clk) begin
    if (wr_fire && mem_sel) begin
      mem[mem_idx]        <= merge(mem[mem_idx], wb_dat_i, wb_sel_i);
      word_set_r[mem_idx] <= 1'b1;
    end
  end

  // Outputs, all straight from flip-flops
  assign wb_ack_o            = ack_r;
  assign wb_dat_o            = rdat_r;
  assign ctrl_out            = pipe_r[15:0];
  assign ctrl_hi_oe          = pipe_r[OE_BIT];
  assign zero_n              = zero_n_r;
  assign diag_shift_clock_o  = diag_shift_clock_o_r;
  assign diag_shift_clock_oe = diag_oe_r;
  assign diag_mode_o         = mode_o_r;
  assign diag_mode_oe        = diag_oe_r;
  assign shadow_serial_out   = sdo_r;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  reset_addr_a:  assert property ($rose(rstn) |-> pc_r == RESET_ADDR && !running ##1 pc_r == RESET_ADDR)
    else $error("address not 63 after reset");
  loop_taken_a:  assert property (running && is_loop && op != OP_LOOP_OR_COND && !ctr_zero && !pipe_load
                   |=> pc_r == $past(data) && loop_counter_r == $past(loop_counter_r) - 6'h01)
    else $error("loop did not decrement and jump");
  loop_fall_a:   assert property (running && op == OP_LOOP_JUMP && !is_cmp && ctr_zero
                   |=> pc_r == $past(pc_inc) && loop_counter_r == 6'h00)
    else $error("loop at zero did not fall through");
  loop_reload_a: assert property (running && op == OP_LOOP_RLD_TEST && !is_cmp && ctr_zero
                   |=> loop_counter_r == $past(test_in))
    else $error("loop reload missed");
  loop_or_a:     assert property (running && op == OP_LOOP_OR_COND && !is_cmp && (ctr_zero || cond)
                   |=> pc_r == $past(data))
    else $error("loop or condition did not branch");
  cond_false_a:  assert property (cond_op && !cond |=> pc_r == $past(pc_inc)
                   && $stable(loop_counter_r) && $stable(return_stack_reg_r))
    else $error("false conditional acted");
  masked_jump_a: assert property (cond_op && op == 5'h02 && cond |=> pc_r == $past(masked))
    else $error("masked jump target wrong");
  call_push_a:   assert property (cond_op && op == 5'h05 && cond
                   |=> pc_r == $past(data) && return_stack_reg_r == $past(pc_inc))
    else $error("call target or return address wrong");
  compare_a:     assert property (running && is_cmp |=> equal_flag_r == $past(cmp_hit))
    else $error("equal flag wrong");
  shift_in_a:    assert property (diag_shift_clock_rise && !diag_mode_i
                   |=> shadow_r == {$past(shadow_r[30:0]), $past(condition_input)})
    else $error("shadow shift wrong");
  capture_a:     assert property (diag_shift_clock_rise && diag_mode_i && !condition_input |=> shadow_r == $past(pipe_r))
    else $error("shadow capture wrong");
  pipe_diag_a:   assert property (pipe_load |=> pipe_r == $past(shadow_r))
    else $error("pipeline not loaded from shadow");
  // Only words software has written are checked; the fetched word is the one addressed a cycle earlier
  pipe_norm_a:   assert property (running && !pipe_load && word_set_r[pc_nxt]
                   |=> pipe_r == $past(mem[pc_nxt]))
    else $error("pipeline not fetched from memory");
  zero_out_a:    assert property (running |=> zero_n == (loop_counter_r != 6'h00))
    else $error("zero output wrong");
  sdo_out_a:     assert property (diag_en_r && $stable(diag_en_r) |=> shadow_serial_out == shadow_r[31])
    else $error("serial out not shadow msb");

  loop_run_c:    cover property (running && op == OP_LOOP_JUMP && !is_cmp && !ctr_zero ##1 running);
  masked_c:      cover property (cond_op && op == 5'h02 && cond);
  diag_shift_c:  cover property (diag_shift_clock_rise && !diag_mode_i ##[1:20] diag_shift_clock_rise && !diag_mode_i);
  diag_load_c:   cover property (pipe_load ##1 !pipe_load ##[1:20] diag_shift_clock_rise && diag_mode_i);

endmodule : mpsd_sequencer

/* File: tb/mpsd_tester.sv */
// Tester model: drives the test inputs and the serial diagnostic pins
`timescale 1ns/100ps
module mpsd_tester (
  // Clock
  input  wire logic       clk,
  // Far-side drive
  output logic      [5:0] test_in,
  output logic            cond_o,
  output logic            sclk_o,
  output logic            mode_o,
  // Serial return
  input  wire logic       ser_in
);
  initial begin
    test_in = 6'h15;
    cond_o  = 1'b0;
    sclk_o  = 1'b0;
    mode_o  = 1'b0;
  end
  // Shift a word in MSB first with mode low; the clock stays low two cycles between rises
  task automatic shift(input logic [31:0] w, output logic [31:0] got);
    for (int i = 31; i >= 0; i--) begin
      @(posedge clk);
      got[i] = ser_in;
      cond_o <= w[i];
      sclk_o <= 1'b1;
      @(posedge clk);
      sclk_o <= 1'b0;
      @(posedge clk);
    end
  endtask : shift
  // One clock of mode high moves the shadow into the pipeline
  task automatic load_pipe();
    @(posedge clk);
    mode_o <= 1'b1;
    @(posedge clk);
    mode_o <= 1'b0;
  endtask : load_pipe
  // Mode high, serial in low and a clock rise take the pipeline back
  task automatic capture();
    @(posedge clk);
    cond_o <= 1'b0;
    mode_o <= 1'b1;
    sclk_o <= 1'b1;
    @(posedge clk);
    mode_o <= 1'b0;
    sclk_o <= 1'b0;
  endtask : capture
endmodule : mpsd_tester

/* File: tb/mpsd_sequencer_test.sv */
// Testbench: runs a loop program, then a shadow-register diagnostic round trip
`timescale 1ns/100ps
module mpsd_sequencer_test;
  import mpsd_pkg::*;
  logic clk, rstn, cyc, stb, we, ack, hi_oe, zero_n, sclk_o, sclk_oe, mode_o, mode_oe, ser_out;
  logic [3:0] sel;
  logic [11:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [15:0] ctrl_out;
  wire logic [5:0] test_in;
  wire logic cond, p_sclk, p_mode, sclk_pin, mode_pin;
  int fail_count, n_checks;
  // Two-way pins resolve from the sequencer's output enables alone
  assign sclk_pin = sclk_oe ? sclk_o : p_sclk;
  assign mode_pin = mode_oe ? mode_o : p_mode;
  mpsd_sequencer DUT (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .test_in(test_in),
    .condition_input(cond), .ctrl_out(ctrl_out), .ctrl_hi_oe(hi_oe), .zero_n(zero_n),
    .diag_shift_clock_i(sclk_pin), .diag_shift_clock_o(sclk_o), .diag_shift_clock_oe(sclk_oe),
    .diag_mode_i(mode_pin), .diag_mode_o(mode_o), .diag_mode_oe(mode_oe), .shadow_serial_out(ser_out));
  mpsd_tester P (.clk(clk), .test_in(test_in), .cond_o(cond), .sclk_o(p_sclk), .mode_o(p_mode), .ser_in(ser_out));
  // One classic cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, d, 4'hF};
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    {cyc, stb} <= 2'h0;
  endtask : wb
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Watchdog at 10000 cycles, well beyond the few hundred cycles the run needs
  initial begin
    #50000;
    fail_count++;
    conclude();
  end
  initial begin
    {rstn, cyc, stb, we, sel, adr, wdat} = '0;
    fail_count = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    // Load ctr=2; loop at 0; compare; false load; self jump
    wb(1, 12'h1FC, 32'h33C20000, q);
    wb(1, 12'h100, 32'h60000000, q);
    wb(1, 12'h104, 32'h757F0000, q);
    wb(1, 12'h108, 32'h33C90000, q);
    wb(1, 12'h10C, 32'h05C30000, q);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (20) @(posedge clk);
    wb(0, REG_STATUS, 0, q);
    chk("status", 32'h03000003, q);
    chk("zero_n", 32'h0, {31'h0, zero_n});
    wb(0, 12'h0F0, 0, q);
    chk("unmapped", 32'h0, q);
    wb(1, REG_CTRL, 32'h1, q);
    // Pin enables drop one cycle after the mode bit lands; look once they have settled
    repeat (2) @(posedge clk);
    chk("pin_oe", 32'h0, {30'h0, sclk_oe, mode_oe});
    P.shift(32'h85C3A5C3, q);
    wb(0, REG_SHADOW, 0, q);
    chk("shadow_in", 32'h85C3A5C3, q);
    chk("serial_out", 32'h1, {31'h0, ser_out});
    P.load_pipe();
    #1;
    chk("pipe_load", 32'h1A5C3, {15'h0, hi_oe, ctrl_out});
    chk("pin_out", 32'h3, {30'h0, sclk_o, mode_o});
    repeat (4) @(posedge clk);
    P.capture();
    wb(0, REG_SHADOW, 0, q);
    chk("shadow_cap", 32'h05C30000, q);
    P.shift(32'h0, q);
    chk("shift_out", 32'h05C30000, q);
    conclude();
  end
endmodule : mpsd_sequencer_test
